// ===== core/isf_bus_cond.sv
// start and stop condition detector on synchronised bus lines
`timescale 1ns/100ps
module isf_bus_cond (
  input  wire logic clk_i,     // core clock
  input  wire logic resetn_i,  // async reset, active low
  input  wire logic scl_s_i,   // synchronised clock line
  input  wire logic sda_s_i,   // synchronised data line
  output logic      start_o,   // start condition, one-cycle pulse
  output logic      stop_o     // stop condition, one-cycle pulse
);

  logic scl_q;
  logic sda_q;
  logic start_q;
  logic stop_q;

  // previous levels, idle bus reads high
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s_i;
      sda_q <= sda_s_i;
    end
  end

  // data edge while clock stays high marks a condition
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      start_q <= 1'b0;
      stop_q  <= 1'b0;
    end else begin
      start_q <= scl_q && scl_s_i && sda_q && !sda_s_i;
      stop_q  <= scl_q && scl_s_i && !sda_q && sda_s_i;
    end
  end

  assign start_o = start_q;
  assign stop_o  = stop_q;

endmodule : isf_bus_cond

// ===== core/isf_cfg.svh
// register offsets, field positions and reset values of the status flag block
`ifndef ISF_CFG_SVH
`define ISF_CFG_SVH

`define ISF_ADDR_W        8
`define ISF_DATA_W        8

`define ISF_CTRL_OFS      8'h00
`define ISF_STAT_OFS      8'h04
`define ISF_SAR2_OFS      8'h08

`define ISF_CTRL_EN_BIT   7
`define ISF_CTRL_MST_BIT  6
`define ISF_CTRL_SYNC_BIT 5
`define ISF_CTRL_IRQ_BIT  1

`define ISF_ERROR_STOP_FLAG_BIT      7
`define ISF_STOP_BIT      6
`define ISF_FRAME_DONE_IRQ_FLAG_BIT      5
`define ISF_SECOND_ADDR_MATCH_FLAG_BIT      4

`define ISF_CTRL_RST      8'h00
`define ISF_STAT_RST      8'h00
`define ISF_SAR2_RST      7'h00

`define ISF_SYNC_STAGES   2

`endif

// ===== core/isf_pkg.sv
// types shared by the status flag block
package isf_pkg;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10
  } isf_phase_e;

  typedef logic [7:0] isf_byte_t;

endpackage : isf_pkg

// ===== core/isf_status_flags.sv
// upper status flags of the two-wire bus interface with its register port
`timescale 1ns/100ps
`include "isf_cfg.svh"
module isf_status_flags (
  input  wire logic                   clk_i,          // core clock, 125 MHz
  input  wire logic                   resetn_i,       // async reset, active low
  input  wire logic [`ISF_ADDR_W-1:0] reg_addr_i,     // register byte address
  input  wire logic [`ISF_DATA_W-1:0] reg_wdata_i,    // register write data
  input  wire logic                   reg_wr_i,       // write strobe
  input  wire logic                   reg_rd_i,       // read strobe
  output isf_pkg::isf_byte_t          reg_rdata_o,    // read data, cycle after strobe
  input  wire logic                   scl_i,          // bus clock pin level
  input  wire logic                   sda_i,          // bus data pin level
  input  wire logic                   frame_busy_i,   // engine: frame in progress
  input  wire logic                   frame_done_i,   // engine: frame received, pulse
  input  wire logic                   slave_rx_i,     // engine: slave receive mode
  input  wire logic [7:0]             frame_byte_i,   // engine: received frame
  input  wire logic                   tx_empty_i,     // transmit empty flag level
  input  wire logic                   rx_full_i,      // receive full flag level
  output logic                        main_irq_o,     // main interrupt flag
  output logic                        enable_o,       // interface enable bit
  output logic                        master_o,       // master mode bit
  output logic                        sync_fmt_o,     // clocked synchronous format
  output logic                        error_stop_o,   // error-stop flag
  output logic                        normal_stop_o,  // normal-stop flag
  output logic                        frame_irq_o,    // frame-done irq flag
  output logic                        addr2_match_o   // second address match flag
);
  import isf_pkg::*;

  logic [1:0]       pins_s;
  logic             start_p;
  logic             stop_p;
  logic             enable_q;
  logic             master_q;
  logic             sync_q;
  logic             irq_q;
  logic             irq_d;
  logic [6:0]       sar2_q;
  logic             error_stop_flag_q;
  logic             stop_q;
  logic             frame_done_irq_flag_q;
  logic             second_addr_match_flag_q;
  logic             seen_error_stop_flag_q;
  logic             seen_stop_q;
  logic             seen_frame_done_irq_flag_q;
  logic             seen_second_addr_match_flag_q;
  logic             tx_empty_q;
  logic             rx_full_q;
  isf_phase_e       phase_q;
  isf_byte_t        rdata_q;
  logic             wr_ctrl;
  logic             wr_stat;
  logic             wr_sar2;
  logic             rd_stat;
  logic             slave_bus;
  logic             data_rise;
  logic             frame_done_irq_flag_set;
  logic             error_stop_flag_set;
  logic             stop_set;
  logic             second_addr_match_flag_set;
  logic             irq_fall;
  logic             clr_error_stop_flag;
  logic             clr_stop;
  logic             clr_frame_done_irq_flag;
  logic             clr_second_addr_match_flag;
  isf_byte_t        stat_view;

  isf_sync #(
    .WIDTH (`ISF_SYNC_STAGES)
  ) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  ({scl_i, sda_i}),
    .sync_o   (pins_s)
  );

  isf_bus_cond u_cond (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .scl_s_i  (pins_s[1]),
    .sda_s_i  (pins_s[0]),
    .start_o  (start_p),
    .stop_o   (stop_p)
  );

  assign wr_ctrl = reg_wr_i && (reg_addr_i == `ISF_CTRL_OFS);
  assign wr_stat = reg_wr_i && (reg_addr_i == `ISF_STAT_OFS);
  assign wr_sar2 = reg_wr_i && (reg_addr_i == `ISF_SAR2_OFS);
  assign rd_stat = reg_rd_i && (reg_addr_i == `ISF_STAT_OFS);

  // bus-format slave: neither master nor clocked synchronous format
  assign slave_bus = enable_q && !master_q && !sync_q;

  // data register flags are levels; only their rising edge requests
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_empty_q <= 1'b0;
      rx_full_q  <= 1'b0;
    end else begin
      tx_empty_q <= tx_empty_i;
      rx_full_q  <= rx_full_i;
    end
  end

  assign data_rise = (tx_empty_i && !tx_empty_q) || (rx_full_i && !rx_full_q);

  assign frame_done_irq_flag_set = enable_q && data_rise &&
                    ((slave_bus && second_addr_match_flag_q) ||
                     master_q || sync_q);

  assign error_stop_flag_set = slave_bus && stop_p && frame_busy_i;
  assign stop_set = slave_bus && stop_p && !frame_busy_i;

  // first frame after start decides the second address match
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_q <= PH_IDLE;
    end else begin
      case (phase_q)
        PH_IDLE: begin
          if (start_p) begin
            phase_q <= PH_ADDR;
          end
        end
        PH_ADDR: begin
          if (stop_p) begin
            phase_q <= PH_IDLE;
          end else if (frame_done_i) begin
            phase_q <= PH_DATA;
          end
        end
        PH_DATA: begin
          if (stop_p) begin
            phase_q <= PH_IDLE;
          end else if (start_p) begin
            phase_q <= PH_ADDR;
          end
        end
        default: begin
          phase_q <= PH_IDLE;
        end
      endcase
    end
  end

  assign second_addr_match_flag_set = slave_bus && slave_rx_i && (phase_q == PH_ADDR) &&
                    frame_done_i && !start_p &&
                    (frame_byte_i[7:1] == sar2_q);

  // main flag falling by software write: the common clear event
  assign irq_fall = wr_ctrl && irq_q && !reg_wdata_i[`ISF_CTRL_IRQ_BIT];

  // software clear needs a read of one first, then a write of zero
  assign clr_error_stop_flag = (wr_stat && seen_error_stop_flag_q && !reg_wdata_i[`ISF_ERROR_STOP_FLAG_BIT]) ||
                    irq_fall;
  assign clr_stop = (wr_stat && seen_stop_q && !reg_wdata_i[`ISF_STOP_BIT]) ||
                    irq_fall;
  assign clr_frame_done_irq_flag = (wr_stat && seen_frame_done_irq_flag_q && !reg_wdata_i[`ISF_FRAME_DONE_IRQ_FLAG_BIT]) ||
                    (irq_fall && enable_q);
  assign clr_second_addr_match_flag = (wr_stat && seen_second_addr_match_flag_q && !reg_wdata_i[`ISF_SECOND_ADDR_MATCH_FLAG_BIT]) ||
                    start_p || master_q;

  // control register; main flag set by hardware, cleared only by software
  always_comb begin
    irq_d = irq_q;
    if (wr_ctrl && !reg_wdata_i[`ISF_CTRL_IRQ_BIT]) begin
      irq_d = 1'b0;
    end
    if (frame_done_irq_flag_set || error_stop_flag_set || stop_set) begin
      irq_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable_q <= 1'b0;
      master_q <= 1'b0;
      sync_q   <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      irq_q <= irq_d;
      if (wr_ctrl) begin
        enable_q <= reg_wdata_i[`ISF_CTRL_EN_BIT];
        master_q <= reg_wdata_i[`ISF_CTRL_MST_BIT];
        sync_q   <= reg_wdata_i[`ISF_CTRL_SYNC_BIT];
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sar2_q <= `ISF_SAR2_RST;
    end else if (wr_sar2) begin
      sar2_q <= reg_wdata_i[7:1];
    end
  end

  // stop flags: a set wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      error_stop_flag_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      if (error_stop_flag_set) begin
        error_stop_flag_q <= 1'b1;
        stop_q <= 1'b0;
      end else if (stop_set) begin
        stop_q <= 1'b1;
        error_stop_flag_q <= 1'b0;
      end else begin
        if (clr_error_stop_flag) begin
          error_stop_flag_q <= 1'b0;
        end
        if (clr_stop) begin
          stop_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frame_done_irq_flag_q <= 1'b0;
    end else if (frame_done_irq_flag_set) begin
      frame_done_irq_flag_q <= 1'b1;
    end else if (clr_frame_done_irq_flag) begin
      frame_done_irq_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      second_addr_match_flag_q <= 1'b0;
    end else if (second_addr_match_flag_set) begin
      second_addr_match_flag_q <= 1'b1;
    end else if (clr_second_addr_match_flag) begin
      second_addr_match_flag_q <= 1'b0;
    end
  end

  // read-of-one tokens; a status write consumes them unless a status read comes in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seen_error_stop_flag_q <= 1'b0;
      seen_stop_q <= 1'b0;
      seen_frame_done_irq_flag_q <= 1'b0;
      seen_second_addr_match_flag_q <= 1'b0;
    end else if (rd_stat) begin
      seen_error_stop_flag_q <= error_stop_flag_q;
      seen_stop_q <= stop_q;
      seen_frame_done_irq_flag_q <= frame_done_irq_flag_q;
      seen_second_addr_match_flag_q <= second_addr_match_flag_q;
    end else if (wr_stat) begin
      seen_error_stop_flag_q <= 1'b0;
      seen_stop_q <= 1'b0;
      seen_frame_done_irq_flag_q <= 1'b0;
      seen_second_addr_match_flag_q <= 1'b0;
    end
  end

  always_comb begin
    stat_view = `ISF_STAT_RST;
    stat_view[`ISF_ERROR_STOP_FLAG_BIT] = error_stop_flag_q;
    stat_view[`ISF_STOP_BIT] = stop_q;
    stat_view[`ISF_FRAME_DONE_IRQ_FLAG_BIT] = frame_done_irq_flag_q;
    stat_view[`ISF_SECOND_ADDR_MATCH_FLAG_BIT] = second_addr_match_flag_q;
  end

  // unmapped addresses read zero; data stand for one cycle only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `ISF_CTRL_OFS: rdata_q <= {enable_q, master_q, sync_q, 3'h0, irq_q, 1'b0};
        `ISF_STAT_OFS: rdata_q <= stat_view;
        `ISF_SAR2_OFS: rdata_q <= {sar2_q, 1'b0};
        default:       rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_o   = rdata_q;
  assign main_irq_o    = irq_q;
  assign enable_o      = enable_q;
  assign master_o      = master_q;
  assign sync_fmt_o    = sync_q;
  assign error_stop_o  = error_stop_flag_q;
  assign normal_stop_o = stop_q;
  assign frame_irq_o   = frame_done_irq_flag_q;
  assign addr2_match_o = second_addr_match_flag_q;

endmodule : isf_status_flags

// ===== core/isf_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module isf_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_i,     // core clock
  input  wire logic             resetn_i,  // async reset, active low
  input  wire logic [WIDTH-1:0] async_i,   // pin levels
  output logic      [WIDTH-1:0] sync_o     // synchronised levels
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : isf_sync

// ===== tb/isf_bus_partner.sv
// two-wire bus master model; link clock runs only inside frames
`timescale 1ns/100ps
module isf_bus_partner (
  output logic scl_o, // bus clock line
  output logic sda_o  // bus data line
);
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  // the 3 ns lead keeps line edges off the core clock edge
  task start_c;
    #3 sda_o = 1'h0;
    #40 scl_o = 1'h0;
  endtask : start_c
  task bits(input int n);
    repeat (n) begin
      #20 sda_o = ~sda_o;
      #20 scl_o = 1'h1;
      #40 scl_o = 1'h0;
    end
  endtask : bits
  task stop_c;
    #20 sda_o = 1'h0;
    #20 scl_o = 1'h1;
    #40 sda_o = 1'h1;
    #40;
  endtask : stop_c
endmodule : isf_bus_partner

// ===== tb/isf_status_flags_checker.sv
// port assertions for the status flag block
`timescale 1ns/100ps
`include "isf_cfg.svh"
module isf_status_flags_checker (
  input wire logic               clk_i,         // core clock
  input wire logic               resetn_i,      // async reset, active low
  input wire logic [7:0]         reg_addr_i,    // register address
  input wire logic [7:0]         reg_wdata_i,   // write data
  input wire logic               reg_wr_i,      // write strobe
  input wire logic               reg_rd_i,      // read strobe
  input wire isf_pkg::isf_byte_t reg_rdata_o,   // read data
  input wire logic               frame_busy_i,  // frame in progress
  input wire logic               frame_done_i,  // frame received
  input wire logic               slave_rx_i,    // slave receive
  input wire logic               tx_empty_i,    // transmit empty
  input wire logic               rx_full_i,     // receive full
  input wire logic               main_irq_o,    // main irq
  input wire logic               enable_o,      // enable bit
  input wire logic               master_o,      // master bit
  input wire logic               sync_fmt_o,    // sync format bit
  input wire logic               error_stop_o,  // error-stop
  input wire logic               normal_stop_o, // normal-stop
  input wire logic               frame_irq_o,   // frame-done irq
  input wire logic               addr2_match_o  // second match
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire irq_clr = reg_wr_i && reg_addr_i == `ISF_CTRL_OFS && !reg_wdata_i[1] && main_irq_o;

  stop_excl_a: assert property (!(error_stop_o && normal_stop_o))
    else $error("both stop flags set");
  stop_mode_a: assert property ($rose(error_stop_o) || $rose(normal_stop_o) |->
    $past(enable_o) && !$past(master_o) && !$past(sync_fmt_o)) else $error("stop mode");
  err_busy_a: assert property ($rose(error_stop_o) |-> $past(frame_busy_i))
    else $error("error stop outside frame");
  ok_busy_a: assert property ($rose(normal_stop_o) |-> !$past(frame_busy_i))
    else $error("normal stop inside frame");
  stop_irq_clr_a: assert property (irq_clr |=> !error_stop_o && !normal_stop_o)
    else $error("stop flag kept after irq clear");
  frame_clr_a: assert property (irq_clr && enable_o |=> !frame_irq_o)
    else $error("frame irq kept after irq clear");
  frame_main_a: assert property ($rose(frame_irq_o) |-> main_irq_o)
    else $error("main irq not set with frame irq");
  frame_set_a: assert property (enable_o && (master_o || sync_fmt_o) &&
    ($rose(tx_empty_i) || $rose(rx_full_i)) |-> ##[0:2] frame_irq_o) else $error("no frame irq");
  frame_why_a: assert property ($rose(frame_irq_o) |->
    $past(tx_empty_i) || $past(rx_full_i)) else $error("frame irq without cause");
  err_clr_a: assert property ($fell(error_stop_o) |-> $past(reg_wr_i) || normal_stop_o)
    else $error("error stop lost");
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read");
  stat_read_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == `ISF_STAT_OFS |->
    reg_rdata_o == {$past(error_stop_o), $past(normal_stop_o), $past(frame_irq_o),
    $past(addr2_match_o), 4'h0}) else $error("status read");
  addr_match_a: assert property ($rose(addr2_match_o) |->
    $past(slave_rx_i) && $past(frame_done_i)) else $error("second match without frame");
endmodule : isf_status_flags_checker

// ===== tb/tb_top.sv
// self-checking bench for the status flag block
`timescale 1ns/100ps
`include "isf_cfg.svh"
module tb_top;
  import isf_pkg::*;
  localparam logic [7:0] C = `ISF_CTRL_OFS;
  localparam logic [7:0] S = `ISF_STAT_OFS;
  logic       clk_i, resetn_i, reg_wr_i, reg_rd_i, scl_w, sda_w;
  logic [7:0] reg_addr_i, reg_wdata_i, frame_byte_i;
  logic       frame_busy_i, frame_done_i, slave_rx_i, tx_empty_i, rx_full_i;
  isf_byte_t  rdata_w;
  logic       irq_w, en_w, mst_w, syn_w, error_stop_flag_w, nstp_w, firq_w, am_w;
  int         mismatches = 0;
  int         checks_done = 0;
  int         cycles = 0;

  isf_status_flags dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata_w),
    .scl_i(scl_w), .sda_i(sda_w), .frame_busy_i(frame_busy_i), .frame_done_i(frame_done_i),
    .slave_rx_i(slave_rx_i), .frame_byte_i(frame_byte_i), .tx_empty_i(tx_empty_i),
    .rx_full_i(rx_full_i), .main_irq_o(irq_w), .enable_o(en_w), .master_o(mst_w),
    .sync_fmt_o(syn_w), .error_stop_o(error_stop_flag_w), .normal_stop_o(nstp_w), .frame_irq_o(firq_w),
    .addr2_match_o(am_w));
  isf_bus_partner peer_u (.scl_o(scl_w), .sda_o(sda_w));

  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // strobe dropped one edge before the next request to avoid double drives
  task automatic wr(input logic [7:0] a, d);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'h1;
    @(posedge clk_i);
    reg_wr_i <= 1'h0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, exp, input string what);
    reg_addr_i <= a;
    reg_rd_i   <= 1'h1;
    @(posedge clk_i);
    reg_rd_i <= 1'h0;
    #1 chk(what, rdata_w, exp);
    // flag pins must agree with the register view while nothing changes
    if (a == C)
      chk({what, " pins"}, {en_w, mst_w, syn_w, 3'h0, irq_w, 1'h0}, exp);
    if (a == S)
      chk({what, " pins"}, {error_stop_flag_w, nstp_w, firq_w, am_w, 4'h0}, exp);
    @(posedge clk_i);
  endtask : rd
  task automatic stop_seq(input logic busy);
    frame_busy_i <= busy;
    peer_u.start_c();
    peer_u.bits(9);
    peer_u.stop_c();
    repeat (9) @(posedge clk_i);
  endtask : stop_seq
  task automatic lvl(input logic via_rx);
    tx_empty_i <= 1'h0;
    rx_full_i  <= 1'h0;
    repeat (2) @(posedge clk_i);
    tx_empty_i <= !via_rx;
    rx_full_i  <= via_rx;
    repeat (3) @(posedge clk_i);
  endtask : lvl

  task automatic t_reset;
    rd(C, 8'h00, "ctrl");
    rd(S, 8'h00, "status");
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'h00, "unmapped");
    $display("test reset done");
  endtask : t_reset
  task automatic t_stops;
    wr(C, 8'h80);
    stop_seq(1'h0);
    rd(S, 8'h40, "stop after frame");
    rd(C, 8'h82, "main irq on stop");
    wr(C, 8'h80);
    rd(S, 8'h00, "stop by irq clear");
    stop_seq(1'h1);
    rd(S, 8'h80, "stop in frame");
    stop_seq(1'h0);
    wr(S, 8'h00);
    rd(S, 8'h40, "clear needs read");
    wr(S, 8'h00);
    rd(S, 8'h00, "stop cleared");
    stop_seq(1'h0);
    stop_seq(1'h1);
    rd(S, 8'h80, "error stop alone");
    wr(S, 8'h00);
    rd(S, 8'h00, "error stop cleared");
    stop_seq(1'h1);
    wr(C, 8'h80);
    rd(S, 8'h00, "error stop by irq clear");
    $display("test stops done");
  endtask : t_stops
  // reset in mid-run with the error-stop flag and main irq raised
  task automatic t_mid_reset;
    wr(C, 8'h80);
    stop_seq(1'h1);
    rd(S, 8'h80, "error stop before reset");
    resetn_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'h1;
    @(posedge clk_i);
    rd(C, 8'h00, "ctrl after reset");
    rd(S, 8'h00, "status after reset");
    $display("test mid reset done");
  endtask : t_mid_reset
  task automatic t_frame_irq(input logic [7:0] mode, input logic via_rx);
    wr(C, mode);
    stop_seq(1'h0);
    rd(S, 8'h00, "stop outside slave");
    lvl(via_rx);
    rd(S, 8'h20, "frame irq");
    rd(C, mode | 8'h02, "main irq with frame");
    wr(C, mode);
    rd(S, 8'h00, "frame irq by irq clear");
    lvl(via_rx);
    wr(C, (mode & 8'h7F) | 8'h02);
    wr(C, mode & 8'h7F);
    rd(S, 8'h20, "frame irq kept when off");
    wr(S, 8'h00);
    rd(S, 8'h00, "frame irq cleared");
    $display("test frame irq done");
  endtask : t_frame_irq
  task automatic t_slave;
    wr(C, 8'h80);
    wr(`ISF_SAR2_OFS, 8'hA4);
    rd(`ISF_SAR2_OFS, 8'hA4, "second address");
    lvl(1'h0);
    rd(S, 8'h00, "frame irq needs match");
    slave_rx_i <= 1'h1;
    peer_u.start_c();
    repeat (8) @(posedge clk_i);
    frame_byte_i <= 8'hA5;
    frame_done_i <= 1'h1;
    @(posedge clk_i);
    frame_done_i <= 1'h0;
    @(posedge clk_i);
    rd(S, 8'h10, "second match");
    lvl(1'h1);
    rd(S, 8'h30, "frame irq on match");
    $display("test slave done");
  endtask : t_slave

  initial begin
    resetn_i = 1'h0;
    {reg_wr_i, reg_rd_i, frame_busy_i, frame_done_i, slave_rx_i, tx_empty_i, rx_full_i} = '0;
    {reg_addr_i, reg_wdata_i, frame_byte_i} = '0;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'h1;
    @(posedge clk_i);
    t_reset();
    t_stops();
    t_mid_reset();
    t_frame_irq(8'hC0, 1'h0);
    t_frame_irq(8'hA0, 1'h1);
    t_slave();
    report_and_stop();
  end
endmodule : tb_top

bind isf_status_flags isf_status_flags_checker chk_u (.*);
